/* File: dbh_buf2.sv */
// two-entry buffer between the pixel source and the bus sequencer
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module dbh_buf2 (
  input wire logic mclk, // clock
  input wire logic srst, // synchronous reset
  input wire logic in_valid, // source offers an item
  output logic in_ready, // buffer has room
  input dbh_pkg::dbh_item_s in_item, // item from source
  output logic out_valid, // head item present
  input wire logic out_ready, // consumer takes head
  output dbh_pkg::dbh_item_s out_item // head item
);
  typedef struct packed {
    dbh_pkg::dbh_item_s [1:0] mem;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } dbh_buf_s;
  dbh_buf_s q, d;
  logic push, pop;

  // handshakes and head view
  assign in_ready = (q.cnt != 2'h2);
  assign out_valid = (q.cnt != 2'h0);
  assign out_item = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and occupancy update
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_item;
      d.wp = ~q.wp;
    end
    if (pop) begin
      d.rp = ~q.rp;
    end
    d.cnt = q.cnt + {1'b0, push} - {1'b0, pop};
  end

  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule : dbh_buf2

/* File: dbh_disp_model.sv */
// display module model: reset spike filter, tearing sync source, word capture
// assumes host pins change on mclk; sync times are shortened for simulation
`timescale 1ns/100ps
module dbh_disp_model #(
  parameter int REJECT_CYC = 200, // 5 us of low before a reset starts
  parameter int GLITCH_CYC = 8, // high runs this short count as spikes
  parameter int TE_HI_CYC = 24, // shortened sync high time
  parameter int TE_PER_CYC = 64 // shortened sync period
) (
  input wire logic mclk, // clock
  input wire logic power_en, // supply is up
  input wire logic ext_reset_n, // reset from host
  input wire logic select_n, // chip select
  input wire logic cmd_data_sel, // command or pixel
  input wire logic write_strobe_n, // write strobe
  input wire logic read_strobe_n, // read strobe
  input dbh_pkg::dbh_word_t bus_d_o, // data pins
  input wire logic bus_d_oe, // data pins driven
  output logic tearing_sync // sync to host
);
  logic [16:0] cap_q[$];
  int low_cnt = 0;
  int hi_cnt = 0;
  int te_cnt = 0;
  logic in_reset = 1'b1;
  logic wr_q = 1'b1;

  // =====================================================================
  // reset filter
  // low time counted on the own clock; short high spikes do not clear it
  always @(posedge mclk) begin
    if (!ext_reset_n) begin
      low_cnt <= low_cnt + 1;
      hi_cnt <= 0;
      if (low_cnt >= REJECT_CYC) in_reset <= 1'b1;
    end else begin
      hi_cnt <= hi_cnt + 1;
      if (hi_cnt >= GLITCH_CYC) begin
        low_cnt <= 0;
        in_reset <= 1'b0;
      end
    end
    if (!power_en) in_reset <= 1'b1;
  end

  // =====================================================================
  // tearing sync: low in reset, pulses when running, garbage unpowered
  initial tearing_sync = 1'b0;
  always @(posedge mclk) begin
    te_cnt <= (te_cnt + 1) % TE_PER_CYC;
    if (!power_en) tearing_sync <= ~tearing_sync;
    else if (in_reset) tearing_sync <= 1'b0;
    else tearing_sync <= (te_cnt < TE_HI_CYC);
  end

  // capture a word on the strobe's rising edge, only when powered and running
  always @(posedge mclk) begin
    wr_q <= write_strobe_n;
    if (power_en && !in_reset && !select_n && read_strobe_n && bus_d_oe && !wr_q && write_strobe_n) begin
      cap_q.push_back({cmd_data_sel, bus_d_o});
    end
  end
endmodule : dbh_disp_model

/* File: dbh_host.sv */
// host controller for a display module on the strobed parallel bus:
// power and reset sequencing, tearing-sync gating and pixel writes
// assumes the pin inputs are synchronous to mclk and power_en follows supply
`timescale 1ns/100ps
module dbh_host #(
  parameter int RESET_CANCEL_CYC = dbh_pkg::RESET_CANCEL_CYC // wait after reset release
) (
  input wire logic mclk, // 40 MHz clock
  input wire logic srst, // synchronous reset, active high
  input wire logic power_en, // display supply is up
  input wire logic hw_reset_req, // pulse: reset the display
  input dbh_pkg::dbh_fmt_e fmt, // colour depth
  input dbh_pkg::dbh_bus_e bus, // bus width in use
  input wire logic pack_opt, // alternative 16-bit bus packing
  input wire logic in_valid, // pixel stream valid
  output logic in_ready, // pixel stream ready
  input dbh_pkg::dbh_item_s in_item, // pixel or command byte
  input wire logic tearing_sync, // sync from display
  output logic ext_reset_n, // display reset, active low
  output logic select_n, // chip select, active low
  output logic cmd_data_sel, // high for pixel data
  output logic write_strobe_n, // write strobe, active low
  output logic read_strobe_n, // read strobe, held high
  output dbh_pkg::dbh_word_t bus_d_o, // data pins out
  output logic bus_d_oe, // data pins driven
  output logic te_valid, // qualified tearing sync
  output logic disp_ready // display usable
);
  // =====================================================================
  // buffer and packer
  // the bus side supports the strobed parallel variant only; no serial
  // option is built, so serial packings never reach the pins
  dbh_pkg::dbh_main_s q, d;
  dbh_pkg::dbh_item_s head;
  dbh_pkg::dbh_pack_s pk;
  logic head_valid;
  logic pop;
  logic last_word;

  dbh_buf2 u_buf (
    .mclk(mclk),
    .srst(srst),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_item(in_item),
    .out_valid(head_valid),
    .out_ready(pop),
    .out_item(head)
  );

  dbh_packer u_pack (
    .item(head),
    .fmt(fmt),
    .bus(bus),
    .opt(pack_opt),
    .half(q.half),
    .nib(q.nib),
    .pk(pk)
  );

  // the head word leaves the buffer after its last word's strobe high time
  assign last_word = ({1'b0, q.idx} + 3'h1) >= {1'b0, pk.cnt};
  assign pop = (q.st == dbh_pkg::ST_STB_HI) && (q.cnt == dbh_pkg::CNT_W'(dbh_pkg::STROBE_HI_CYC - 1))
    && last_word;

  // =====================================================================
  // sequencer
  always_comb begin
    d = q;
    d.rd_n = 1'b1;
    case (q.st)
      dbh_pkg::ST_OFF: begin
        if (power_en) begin
          d.st = dbh_pkg::ST_RST_LOW;
          d.cnt = '0;
        end
      end
      dbh_pkg::ST_RST_LOW: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == dbh_pkg::CNT_W'(dbh_pkg::RESET_LOW_CYC - 1)) begin
          d.rst_n = 1'b1;
          d.st = dbh_pkg::ST_RST_WAIT;
          d.cnt = '0;
        end
      end
      dbh_pkg::ST_RST_WAIT: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == dbh_pkg::CNT_W'(RESET_CANCEL_CYC - 1)) begin
          d.st = dbh_pkg::ST_IDLE;
          d.ready = 1'b1;
          d.cnt = '0;
        end
      end
      dbh_pkg::ST_IDLE: begin
        if (head_valid) begin
          d.st = dbh_pkg::ST_SETUP;
          d.sel_n = 1'b0;
          d.dc = ~head.is_cmd;
          d.d = pk.w[0];
          d.oe = 1'b1;
          d.idx = 2'h0;
        end
      end
      dbh_pkg::ST_SETUP: begin
        // select and data settle one cycle before the strobe falls
        d.st = dbh_pkg::ST_STB_LO;
        d.wr_n = 1'b0;
        d.cnt = '0;
      end
      dbh_pkg::ST_STB_LO: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == dbh_pkg::CNT_W'(dbh_pkg::STROBE_LO_CYC - 1)) begin
          d.st = dbh_pkg::ST_STB_HI;
          d.wr_n = 1'b1;
          d.cnt = '0;
        end
      end
      dbh_pkg::ST_STB_HI: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == dbh_pkg::CNT_W'(dbh_pkg::STROBE_HI_CYC - 1)) begin
          d.cnt = '0;
          if (!last_word) begin
            // next word is loaded only after the high time, so data holds past the rise
            d.idx = q.idx + 2'h1;
            d.d = pk.w[q.idx + 2'h1];
            d.st = dbh_pkg::ST_SETUP;
          end else begin
            d.st = dbh_pkg::ST_IDLE;
            d.sel_n = 1'b1;
            d.oe = 1'b0;
            // 12-bit pixels pair up on the 8-bit bus; a last pixel closes the pair
            if (fmt == dbh_pkg::FMT_12 && bus != dbh_pkg::BUS_16 && !head.is_cmd) begin
              d.half = head.last ? 1'b0 : ~q.half;
              d.nib = head.b[7:4];
            end
          end
        end
      end
      default: begin
        d = dbh_pkg::MAIN_RST;
      end
    endcase
    // a reset request restarts the reset pulse from any powered state
    if (hw_reset_req && q.st != dbh_pkg::ST_OFF) begin
      d.st = dbh_pkg::ST_RST_LOW;
      d.cnt = '0;
      d.rst_n = 1'b0;
      d.sel_n = 1'b1;
      d.wr_n = 1'b1;
      d.oe = 1'b0;
      d.ready = 1'b0;
      d.half = 1'b0;
    end
    // supply off: reset held low, bus parked idle
    if (!power_en) begin
      d.st = dbh_pkg::ST_OFF;
      d.cnt = '0;
      d.rst_n = 1'b0;
      d.sel_n = 1'b1;
      d.wr_n = 1'b1;
      d.oe = 1'b0;
      d.ready = 1'b0;
      d.half = 1'b0;
    end
    // sync only trusted while the display is up and out of reset
    d.te_v = tearing_sync && q.ready && power_en;
  end

  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      q <= dbh_pkg::MAIN_RST;
    end else begin
      q <= d;
    end
  end

  // =====================================================================
  // outputs, all from the state register
  assign ext_reset_n = q.rst_n;
  assign select_n = q.sel_n;
  assign cmd_data_sel = q.dc;
  assign write_strobe_n = q.wr_n;
  assign read_strobe_n = q.rd_n;
  assign bus_d_o = q.d;
  assign bus_d_oe = q.oe;
  assign te_valid = q.te_v;
  assign disp_ready = q.ready;

  // =====================================================================
  // checks
  int low_run;
  int high_run;
  logic [7:0] px_r_q;

  // run lengths of the reset line, and the head pixel's red seen at the strobe
  always_ff @(posedge mclk) begin
    if (srst || q.st == dbh_pkg::ST_OFF) begin
      low_run <= 0;
    end else if (!ext_reset_n) begin
      low_run <= low_run + 1;
    end else begin
      low_run <= 0;
    end
    if (srst || !ext_reset_n) begin
      high_run <= 0;
    end else if (high_run < RESET_CANCEL_CYC) begin
      high_run <= high_run + 1;
    end
    px_r_q <= head.r;
  end

  a_reset_width: assert property (
    @(posedge mclk) disable iff (srst)
    $rose(ext_reset_n) |-> (low_run >= dbh_pkg::RESET_LOW_MIN_CYC) && (low_run <= dbh_pkg::RESET_LOW_MAX_CYC)
  ) else $error("reset pulse width out of range");

  a_ready_wait: assert property (
    @(posedge mclk) disable iff (srst)
    $rose(disp_ready) |-> ext_reset_n && (high_run >= RESET_CANCEL_CYC)
  ) else $error("display used before reset settled");

  a_power_park: assert property (
    @(posedge mclk) disable iff (srst)
    $past(!power_en) |-> !ext_reset_n && select_n && write_strobe_n && !bus_d_oe && !disp_ready
  ) else $error("bus not parked while power is off");

  a_reset_quiet: assert property (
    @(posedge mclk) disable iff (srst)
    !ext_reset_n |-> select_n && write_strobe_n && !bus_d_oe
  ) else $error("bus active while reset is low");

  a_read_idle: assert property (
    @(posedge mclk) disable iff (srst)
    !disp_ready |-> read_strobe_n && write_strobe_n ##1 read_strobe_n
  ) else $error("strobe not idle high");

  a_te_gate: assert property (
    @(posedge mclk) disable iff (srst)
    te_valid |-> $past(tearing_sync) && $past(disp_ready) && $past(power_en)
  ) else $error("sync passed while display not ready");

  a_strobe_frame: assert property (
    @(posedge mclk) disable iff (srst)
    $fell(write_strobe_n) |-> $past(!select_n) && bus_d_oe ##1 (write_strobe_n && (!select_n || !ext_reset_n)) [*2]
  ) else $error("strobe timing or select framing broken");

  a_data_hold: assert property (
    @(posedge mclk) disable iff (srst)
    $rose(write_strobe_n) && power_en |-> $stable(bus_d_o) ##1 $stable(bus_d_o)
  ) else $error("data changed around strobe rise");

  a_pack_332: assert property (
    @(posedge mclk) disable iff (srst)
    $fell(write_strobe_n) && fmt == dbh_pkg::FMT_8 && bus == dbh_pkg::BUS_8 && cmd_data_sel
      |-> bus_d_o[7:5] == px_r_q[7:5] && bus_d_o[15:8] == 8'h00
  ) else $error("8bpp red field misplaced");

  a_pack_565: assert property (
    @(posedge mclk) disable iff (srst)
    $fell(write_strobe_n) && fmt == dbh_pkg::FMT_16 && bus == dbh_pkg::BUS_16 && cmd_data_sel
      |-> bus_d_o[15:11] == px_r_q[7:3]
  ) else $error("16bpp red field misplaced");

  c_power_up: cover property (@(posedge mclk) disable iff (srst) $rose(disp_ready));
  c_rgb24_px: cover property (@(posedge mclk) disable iff (srst)
    pop && fmt == dbh_pkg::FMT_24 && bus == dbh_pkg::BUS_8);
  c_pair12: cover property (@(posedge mclk) disable iff (srst) pop && q.half && fmt == dbh_pkg::FMT_12);
  c_sync_seen: cover property (@(posedge mclk) disable iff (srst) $rose(te_valid));
endmodule : dbh_host

/* File: dbh_packer.sv */
// turns one pixel or command byte into the words that go onto the data pins
// assumes the caller holds the 12-bit pairing state for the 8-bit bus
`timescale 1ns/100ps
module dbh_packer (
  input dbh_pkg::dbh_item_s item, // pixel or command
  input dbh_pkg::dbh_fmt_e fmt, // colour depth
  input dbh_pkg::dbh_bus_e bus, // bus width
  input wire logic opt, // alternative packing on 16-bit bus
  input wire logic half, // second pixel of a 12-bit pair
  input wire logic [3:0] nib, // blue nibble kept from first pixel
  output dbh_pkg::dbh_pack_s pk // words and their count
);
  logic [7:0] r, g, b;
  assign r = item.r;
  assign g = item.g;
  assign b = item.b;

  // packing table
  always_comb begin
    pk = '0;
    pk.cnt = 2'h1;
    if (item.is_cmd) begin
      pk.w[0] = {8'h00, r};
    end else if (bus == dbh_pkg::BUS_16) begin
      case (fmt)
        dbh_pkg::FMT_8: pk.w[0] = {8'h00, r[7:5], g[7:5], b[7:6]};
        dbh_pkg::FMT_12: pk.w[0] = {4'h0, r[7:4], g[7:4], b[7:4]};
        dbh_pkg::FMT_16: pk.w[0] = {r[7:3], g[7:2], b[7:3]};
        dbh_pkg::FMT_18: begin
          pk.cnt = 2'h2;
          pk.w[0] = opt ? {r[7:2], g[7:2], b[7:4]} : {r[7:2], 2'b00, g[7:2], 2'b00};
          pk.w[1] = opt ? {b[3:2], 14'h0000} : {b[7:2], 2'b00, 8'h00};
        end
        default: begin
          pk.cnt = 2'h2;
          pk.w[0] = opt ? {8'h00, r} : {r, g};
          pk.w[1] = opt ? {g, b} : {b, 8'h00};
        end
      endcase
    end else if (bus == dbh_pkg::BUS_9 && fmt == dbh_pkg::FMT_18) begin
      pk.cnt = 2'h2;
      pk.w[0] = {7'h00, r[7:2], g[7:5]};
      pk.w[1] = {7'h00, g[4:2], b[7:2]};
    end else begin
      case (fmt)
        dbh_pkg::FMT_8: pk.w[0] = {8'h00, r[7:5], g[7:5], b[7:6]};
        dbh_pkg::FMT_12: begin
          pk.cnt = (half || item.last) ? 2'h2 : 2'h1;
          pk.w[0] = half ? {8'h00, nib, r[7:4]} : {8'h00, r[7:4], g[7:4]};
          pk.w[1] = half ? {8'h00, g[7:4], b[7:4]} : {8'h00, b[7:4], 4'h0};
        end
        dbh_pkg::FMT_16: begin
          pk.cnt = 2'h2;
          pk.w[0] = {8'h00, r[7:3], g[7:5]};
          pk.w[1] = {8'h00, g[4:2], b[7:3]};
        end
        dbh_pkg::FMT_18: begin
          pk.cnt = 2'h3;
          pk.w[0] = {8'h00, r[7:2], 2'b00};
          pk.w[1] = {8'h00, g[7:2], 2'b00};
          pk.w[2] = {8'h00, b[7:2], 2'b00};
        end
        default: begin
          pk.cnt = 2'h3;
          pk.w[0] = {8'h00, r};
          pk.w[1] = {8'h00, g};
          pk.w[2] = {8'h00, b};
        end
      endcase
    end
  end
endmodule : dbh_packer

/* File: dbh_pkg.sv */
// constants, modes, carriers and state types for the display bus host
// assumes one clock, mclk, at 40 MHz and a synchronous active-high reset
package dbh_pkg;
  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int RESET_LOW_MIN_US = 10;
  localparam int RESET_LOW_MAX_US = 50;
  localparam int RESET_LOW_US = 20;
  localparam int RESET_LOW_CYC = (RESET_LOW_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_LOW_MIN_CYC = (RESET_LOW_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RESET_LOW_MAX_CYC = (RESET_LOW_MAX_US * 1000) / CLK_PERIOD_NS;
  localparam int RESET_CANCEL_MS = 5;
  localparam int RESET_CANCEL_CYC = (RESET_CANCEL_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_LO_NS = 20;
  localparam int STROBE_HI_NS = 30;
  localparam int STROBE_LO_CYC = (STROBE_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_HI_CYC = (STROBE_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 18;

  // =====================================================================
  // modes and carriers
  typedef enum logic [2:0] {
    FMT_8 = 3'h0, FMT_12 = 3'h1, FMT_16 = 3'h2, FMT_18 = 3'h3, FMT_24 = 3'h4
  } dbh_fmt_e;
  typedef enum logic [1:0] {BUS_8 = 2'h0, BUS_9 = 2'h1, BUS_16 = 2'h2} dbh_bus_e;
  typedef logic [15:0] dbh_word_t;
  typedef struct packed {
    logic is_cmd;
    logic last;
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } dbh_item_s;
  typedef struct packed {
    dbh_word_t [2:0] w;
    logic [1:0] cnt;
  } dbh_pack_s;

  // =====================================================================
  // controller state
  typedef enum logic [2:0] {
    ST_OFF = 3'h0, ST_RST_LOW = 3'h1, ST_RST_WAIT = 3'h2, ST_IDLE = 3'h3,
    ST_SETUP = 3'h4, ST_STB_LO = 3'h5, ST_STB_HI = 3'h6
  } dbh_state_e;
  typedef struct packed {
    dbh_state_e st;
    logic [CNT_W-1:0] cnt;
    logic [1:0] idx;
    logic half;
    logic [3:0] nib;
    logic rst_n;
    logic sel_n;
    logic dc;
    logic wr_n;
    logic rd_n;
    dbh_word_t d;
    logic oe;
    logic te_v;
    logic ready;
  } dbh_main_s;
  localparam dbh_main_s MAIN_RST = '{st: ST_OFF, cnt: '0, idx: 2'h0, half: 1'b0, nib: 4'h0,
    rst_n: 1'b0, sel_n: 1'b1, dc: 1'b1, wr_n: 1'b1, rd_n: 1'b1, d: 16'h0000, oe: 1'b0,
    te_v: 1'b0, ready: 1'b0};
endpackage : dbh_pkg

/* File: testbench.sv */
// self-checking bench for the display bus host against a display model
// assumes dbh_pkg, the design files and dbh_disp_model are compiled first
`timescale 1ns/100ps
module testbench;
  localparam int CANCEL = 20; // shortened reset cancel wait
  localparam dbh_pkg::dbh_item_s PX = {2'b01, 24'hb56cd3}; // lone last pixel
  localparam dbh_pkg::dbh_item_s PE = {2'b00, 24'hb56cd3}; // even pixel of a pair
  localparam dbh_pkg::dbh_item_s PO = {2'b01, 24'h123456}; // odd last pixel
  localparam dbh_pkg::dbh_item_s CMD = {2'b11, 24'h2c0000}; // command byte
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic power_en = 1'b0;
  logic hw_reset_req = 1'b0;
  dbh_pkg::dbh_fmt_e fmt = dbh_pkg::FMT_8;
  dbh_pkg::dbh_bus_e bus = dbh_pkg::BUS_8;
  logic pack_opt = 1'b0;
  logic in_valid = 1'b0;
  dbh_pkg::dbh_item_s in_item = '0;
  logic in_ready, tearing_sync, ext_reset_n, select_n, cmd_data_sel, write_strobe_n;
  logic read_strobe_n, bus_d_oe, te_valid, disp_ready;
  dbh_pkg::dbh_word_t bus_d_o;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;

  // =====================================================================
  // clock, design, display model, watchdog
  always #12.5 mclk = ~mclk;

  dbh_host #(.RESET_CANCEL_CYC(CANCEL)) uut (.mclk(mclk), .srst(srst), .power_en(power_en),
    .hw_reset_req(hw_reset_req), .fmt(fmt), .bus(bus), .pack_opt(pack_opt), .in_valid(in_valid),
    .in_ready(in_ready), .in_item(in_item), .tearing_sync(tearing_sync), .ext_reset_n(ext_reset_n),
    .select_n(select_n), .cmd_data_sel(cmd_data_sel), .write_strobe_n(write_strobe_n),
    .read_strobe_n(read_strobe_n), .bus_d_o(bus_d_o), .bus_d_oe(bus_d_oe), .te_valid(te_valid),
    .disp_ready(disp_ready));

  dbh_disp_model disp (.mclk(mclk), .power_en(power_en), .ext_reset_n(ext_reset_n), .select_n(select_n),
    .cmd_data_sel(cmd_data_sel), .write_strobe_n(write_strobe_n), .read_strobe_n(read_strobe_n),
    .bus_d_o(bus_d_o), .bus_d_oe(bus_d_oe), .tearing_sync(tearing_sync));

  // cut a hang short
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      error_cnt++;
      summarize();
    end
  end

  // =====================================================================
  // shared tasks
  task automatic summarize();
    if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s got %b", $time, msg, got);
    end
  endtask : chk_bit

  task automatic chk_word(input logic [16:0] got, input logic [16:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %0t %s got %h want %h", $time, msg, got, exp);
    end
  endtask : chk_word

  // offer one item at a falling edge and hold it until taken
  task automatic offer(input dbh_pkg::dbh_item_s it);
    int n;
    n = 0;
    in_valid = 1'b1;
    in_item = it;
    while (in_ready !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    in_valid = 1'b0;
  endtask : offer

  // collect words from the display and wait for select to rise
  task automatic expect_words(input int cnt, input logic [16:0] w0, input logic [16:0] w1, input logic [16:0] w2);
    logic [16:0] w [3];
    int n;
    w = '{w0, w1, w2};
    n = 0;
    while ((disp.cap_q.size() < cnt || select_n !== 1'b1) && n < 400) begin
      @(negedge mclk);
      n++;
    end
    chk_bit(disp.cap_q.size() == cnt, 1'b1, "word count");
    for (int i = 0; i < cnt && disp.cap_q.size() > 0; i++) chk_word(disp.cap_q.pop_front(), w[i], "word");
  endtask : expect_words

  task automatic send(input dbh_pkg::dbh_fmt_e f, input dbh_pkg::dbh_bus_e b, input logic o,
    input dbh_pkg::dbh_item_s it, input int cnt, input logic [16:0] w0, input logic [16:0] w1, input logic [16:0] w2);
    fmt = f;
    bus = b;
    pack_opt = o;
    offer(it);
    expect_words(cnt, w0, w1, w2);
  endtask : send

  // pins parked while the display is off or in reset
  task automatic parked();
    chk_bit(ext_reset_n, 1'b0, "reset pin");
    chk_bit(select_n, 1'b1, "select");
    chk_bit(write_strobe_n, 1'b1, "write strobe");
    chk_bit(read_strobe_n, 1'b1, "read strobe");
    chk_bit(bus_d_oe, 1'b0, "data drive");
    chk_bit(te_valid, 1'b0, "sync gate");
    chk_bit(disp_ready, 1'b0, "ready");
  endtask : parked

  // reset low width and cancel wait until the display is usable
  task automatic wait_ready();
    int n;
    n = 0;
    while (ext_reset_n !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      chk_bit(select_n, 1'b1, "select in reset");
      n++;
    end
    chk_bit(n >= dbh_pkg::RESET_LOW_MIN_CYC && n <= dbh_pkg::RESET_LOW_MAX_CYC, 1'b1, "reset width");
    n = 0;
    while (disp_ready !== 1'b1 && n < 1000) begin
      @(negedge mclk);
      n++;
    end
    chk_bit(n >= CANCEL && n <= CANCEL + 2, 1'b1, "cancel wait");
  endtask : wait_ready

  // =====================================================================
  // scenarios
  task automatic t_buffer();
    fmt = dbh_pkg::FMT_24;
    offer(PX);
    offer(PO);
    chk_bit(in_ready, 1'b0, "buffer full");
    power_en = 1'b1;
    wait_ready();
    expect_words(3, 17'h100b5, 17'h1006c, 17'h100d3);
    expect_words(3, 17'h10012, 17'h10034, 17'h10056);
  endtask : t_buffer

  task automatic t_pixels();
    send(dbh_pkg::FMT_8, dbh_pkg::BUS_8, 1'b0, PX, 1, 17'h100af, 17'h0, 17'h0);
    send(dbh_pkg::FMT_12, dbh_pkg::BUS_8, 1'b0, PX, 2, 17'h100b6, 17'h100d0, 17'h0);
    send(dbh_pkg::FMT_12, dbh_pkg::BUS_8, 1'b0, PE, 1, 17'h100b6, 17'h0, 17'h0);
    send(dbh_pkg::FMT_12, dbh_pkg::BUS_8, 1'b0, PO, 2, 17'h100d1, 17'h10035, 17'h0);
    send(dbh_pkg::FMT_16, dbh_pkg::BUS_8, 1'b0, PX, 2, 17'h100b3, 17'h1007a, 17'h0);
    send(dbh_pkg::FMT_18, dbh_pkg::BUS_8, 1'b0, PX, 3, 17'h100b4, 17'h1006c, 17'h100d0);
    send(dbh_pkg::FMT_18, dbh_pkg::BUS_9, 1'b0, PX, 2, 17'h1016b, 17'h100f4, 17'h0);
    send(dbh_pkg::FMT_8, dbh_pkg::BUS_16, 1'b0, PX, 1, 17'h100af, 17'h0, 17'h0);
    send(dbh_pkg::FMT_12, dbh_pkg::BUS_16, 1'b0, PX, 1, 17'h10b6d, 17'h0, 17'h0);
    send(dbh_pkg::FMT_16, dbh_pkg::BUS_16, 1'b0, PX, 1, 17'h1b37a, 17'h0, 17'h0);
    send(dbh_pkg::FMT_18, dbh_pkg::BUS_16, 1'b0, PX, 2, 17'h1b46c, 17'h1d000, 17'h0);
    send(dbh_pkg::FMT_18, dbh_pkg::BUS_16, 1'b1, PX, 2, 17'h1b5bd, 17'h10000, 17'h0);
    send(dbh_pkg::FMT_24, dbh_pkg::BUS_16, 1'b0, PX, 2, 17'h1b56c, 17'h1d300, 17'h0);
    send(dbh_pkg::FMT_24, dbh_pkg::BUS_16, 1'b1, PX, 2, 17'h100b5, 17'h16cd3, 17'h0);
    send(dbh_pkg::FMT_8, dbh_pkg::BUS_8, 1'b0, CMD, 1, 17'h0002c, 17'h0, 17'h0);
  endtask : t_pixels

  // qualified sync follows the display's sync one cycle late
  task automatic t_sync();
    int n;
    n = 0;
    while (tearing_sync !== 1'b1 && n < 200) begin
      @(negedge mclk);
      n++;
    end
    @(negedge mclk);
    chk_bit(te_valid, 1'b1, "sync valid");
  endtask : t_sync

  // hardware reset with an item waiting in the buffer
  task automatic t_hw_reset();
    fmt = dbh_pkg::FMT_8;
    bus = dbh_pkg::BUS_8;
    hw_reset_req = 1'b1;
    @(negedge mclk);
    hw_reset_req = 1'b0;
    @(negedge mclk);
    parked();
    offer(PX);
    wait_ready();
    expect_words(1, 17'h100af, 17'h0, 17'h0);
  endtask : t_hw_reset

  // power off parks the pins and gates the garbage sync, then recovers
  task automatic t_power_off();
    power_en = 1'b0;
    repeat (2) @(negedge mclk);
    parked();
    repeat (8) begin
      @(negedge mclk);
      chk_bit(te_valid, 1'b0, "sync gated off");
    end
    power_en = 1'b1;
    wait_ready();
    send(dbh_pkg::FMT_8, dbh_pkg::BUS_8, 1'b0, PX, 1, 17'h100af, 17'h0, 17'h0);
  endtask : t_power_off

  // =====================================================================
  // main sequence
  initial begin
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    @(negedge mclk);
    parked();
    t_buffer();
    t_pixels();
    t_sync();
    t_hw_reset();
    t_power_off();
    summarize();
  end
endmodule : testbench
